/* ppm_highway_model.sv */
/*
  PCM highway far side: frame sync source and pin resolution for the transmit pins.
  Assumes a 2.048 MHz data clock, so 256 bits make one 8 kHz frame.
*/
`timescale 1ns/1ps
module ppm_highway_model (
  input wire logic clk_i,
  input wire logic fs_drive_i,
  input wire logic fs_value_i,
  input wire logic [3:0] tx_value_i,
  input wire logic [3:0] tx_oe_i,
  input wire logic [1:0] weak_low_i,
  output logic fs_pin_o,
  output logic [3:0] tx_pin_o
);
  logic [7:0] cnt_q = 8'h00;
  logic fs_q = 1'b0;
  always @(posedge clk_i)
  begin
    cnt_q <= cnt_q + 8'h01;
    fs_q <= (cnt_q == 8'hFF);
  end
  // Device drive wins; otherwise our own 8 kHz sync
  assign fs_pin_o = fs_drive_i ? fs_value_i : fs_q;
  // Open-drain lines carry an external pull-up
  assign tx_pin_o[0] = tx_oe_i[0] ? tx_value_i[0] : 1'b1;
  assign tx_pin_o[1] = tx_oe_i[1] ? tx_value_i[1] : 1'b1;
  // Undriven and not pulled: a changing level, never a stale one
  assign tx_pin_o[2] = tx_oe_i[2] ? tx_value_i[2] : (weak_low_i[0] ? 1'b0 : cnt_q[0]);
  assign tx_pin_o[3] = tx_oe_i[3] ? tx_value_i[3] : (weak_low_i[1] ? 1'b0 : cnt_q[0]);
endmodule

/* ppm_lc_chan.sv */
/*
  One line-controller channel: next values for its shared pins and its external clock divider.
  Assumes the top registers every value it returns and that inputs are already synchronised.
*/
`timescale 1ns/1ps
module ppm_lc_chan (
  input logic clk_i,
  input logic rst_i,
  ppm_lc_if.chan lc
);
  import ppm_pkg::*;

  logic [2:0] cnt_q;
  logic clk_q;
  logic [2:0] half_last;
  logic run;

  // ***************************************************
  // External clock divider
  // ***************************************************
  assign half_last = 3'((4'h1 << lc.div) - 4'h1);
  assign run = lc.sel & lc.clk_out;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run)
    begin
      cnt_q <= 3'h0;
      clk_q <= 1'b0;
    end
    else if (cnt_q == half_last)
    begin
      cnt_q <= 3'h0;
      clk_q <= ~clk_q;
    end
    else
    begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // ***************************************************
  // Pin functions
  // ***************************************************
  // Open drain: only ever pull low, never drive high
  assign lc.tx_oe_d = lc.sel & lc.tx_valid & ~lc.tx_bit;
  assign lc.drv_n_d = lc.async_mode ? ~lc.rts : ~lc.tx_valid;
  assign lc.clk_d = clk_q;
  assign lc.rx_d = lc.sel & lc.rx_s;
  assign lc.col_d = lc.sel & ~lc.async_mode & lc.cxd_s;
  assign lc.cts_d = lc.sel & lc.async_mode & lc.cxd_s;
  assign lc.ext_clk_d = lc.sel & ~lc.clk_out & lc.clk_s;

endmodule

/* ppm_lc_if.sv */
/*
  Carrier between the pin-sharing top and one line-controller channel.
  Assumes every signal lives in the link clock domain.
*/
`timescale 1ns/1ps
interface ppm_lc_if;
  logic sel;
  logic async_mode;
  logic clk_out;
  logic [1:0] div;
  logic tx_bit;
  logic tx_valid;
  logic rts;
  logic rx_s;
  logic cxd_s;
  logic clk_s;
  logic tx_oe_d;
  logic drv_n_d;
  logic clk_d;
  logic rx_d;
  logic col_d;
  logic cts_d;
  logic ext_clk_d;

  modport top (
    output sel, async_mode, clk_out, div, tx_bit, tx_valid, rts, rx_s, cxd_s, clk_s,
    input tx_oe_d, drv_n_d, clk_d, rx_d, col_d, cts_d, ext_clk_d
  );
  modport chan (
    input sel, async_mode, clk_out, div, tx_bit, tx_valid, rts, rx_s, cxd_s, clk_s,
    output tx_oe_d, drv_n_d, clk_d, rx_d, col_d, cts_d, ext_clk_d
  );
endinterface

/* ppm_pkg.sv */
/*
  Shared constants and types for the PCM port / line-controller pin sharing block.
  Assumes a 32-bit AXI4-Lite register bus and a link clock taken from the PCM data clock pin.
*/
package ppm_pkg;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam int CTRL_WIDTH = 19;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 19'h00000;
  localparam int ST_CFG_ERR = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_LC_IN_LSB = 2;

  // ***************************************************
  // Bus responses
  // ***************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ***************************************************
  // Clock rates: code n means 2.048 MHz times 2**n
  // ***************************************************
  localparam logic [1:0] RATE_2M048 = 2'h0;
  localparam logic [1:0] RATE_4M096 = 2'h1;
  localparam logic [1:0] RATE_8M192 = 2'h2;
  localparam logic [1:0] RATE_16M384 = 2'h3;
  localparam int FS_HZ = 8000;
  localparam int BCLK_BASE_HZ = 2048000;
  localparam int FRAME_BITS_BASE = BCLK_BASE_HZ / FS_HZ;
  localparam int FRAME_CNT_W = 11;

  // Control register layout, bit 0 is fs_out
  typedef struct packed {
    logic [1:0][1:0] lc_rate;
    logic [1:0] lc_clk_out;
    logic [1:0] lc_async;
    logic [1:0] lc_sel;
    logic [3:0] tx_en;
    logic [1:0] bclk_rate;
    logic bclk_out;
    logic fs_4k;
    logic fs_out;
  } ppm_cfg_t;

endpackage

/* ppm_top.sv */
/*
  Pin sharing for four PCM highway ports and line-controller channels 2 and 3, with AXI4-Lite control.
  Assumes pcm_bit_clk_i is the data clock seen at the pin and pads resolve the enables.
*/
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
// Contract
// - Frame sync input may be 8 or 4 kHz; driven output is 8 kHz only.
// - With 4 kHz frame sync input, data clock must be a 2.048 MHz input.
// - Data clock is input or output at 2.048, 4.096, 8.192 or 16.384 MHz.
// - Port driver-enable is low exactly while its transmit data is valid; the code also requires the port's tx_en bit.
// - Port driver-enable pins are high once reset has finished.
// - Channel driver pin is transmit-valid enable in HDLC, request-to-send in async.
// - Shared receive pin of ports 2 and 3 is collision in HDLC, clear-to-send async.
// - Channel clock pins are bidirectional; driven output uses the listed rates; the code drives only 2.048 to 8.192 MHz, below the data clock.
// - Channels take data over port 0 and 1 pins; transmit is open drain.
// - Port 0 and 1 transmit pins float until configured to drive.
// - Port 2 and 3 transmit pins hold weak low until configured otherwise.
`timescale 1ns/1ps
module ppm_top #(
  parameter int N_PORTS = 4
) (
  input logic clock_i,
  input logic srst_i,
  input logic pcm_bit_clk_i,
  input logic [ppm_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input logic [31:0] s_axi_wdata_i,
  input logic [3:0] s_axi_wstrb_i,
  input logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input logic s_axi_bready_i,
  input logic [ppm_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input logic s_axi_rready_i,
  input logic pcm_frame_sync_i,
  output logic pcm_frame_sync_o,
  output logic pcm_frame_sync_oe_o,
  output logic pcm_bit_clock_oe_o,
  input logic [N_PORTS-1:0] pcm_rx_port_i,
  input logic [N_PORTS-1:0] pcm_tx_port_i,
  output logic [N_PORTS-1:0] pcm_tx_port_o,
  output logic [N_PORTS-1:0] pcm_tx_port_oe_o,
  output logic [1:0] pcm_tx_weak_low_o,
  output logic [N_PORTS-1:0] pcm_drv_enable_n_o,
  input logic [N_PORTS-1:0] pcm_tx_data_i,
  input logic [N_PORTS-1:0] pcm_tx_valid_i,
  output logic [N_PORTS-1:0] pcm_rx_data_o,
  output logic pcm_frame_pulse_o,
  input logic [1:0] line_tx_i,
  input logic [1:0] line_tx_valid_i,
  input logic [1:0] line_rts_i,
  output logic [1:0] line_rx_o,
  output logic [1:0] line_collision_o,
  output logic [1:0] line_cts_o,
  output logic [1:0] line_ext_clk_o
);
  import ppm_pkg::*;

  // ***************************************************
  // System domain state
  // ***************************************************
  ppm_cfg_t cfg_q;
  ppm_cfg_t cfg_new;
  logic err_q;
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic lack_q;
  logic [1:0] lin_s1_q;
  logic [1:0] lin_s2_q;
  logic busy;
  logic aw_pend_q;
  logic aw_pend_d;
  logic w_pend_q;
  logic w_pend_d;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic bvalid_d;
  logic rvalid_d;
  logic wr_ctrl;
  logic wr_status;
  logic rd_ctrl;
  logic rd_status;
  logic [31:0] wmask;
  logic ctrl_take;
  logic ctrl_bad;
  logic err_clr;
  logic [1:0] bresp_d;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;

  // and the divider bound are checked before a setting is applied
  function automatic logic cfg_ok(input ppm_cfg_t c);
    logic ok;
    ok = 1'b1;
    if (c.fs_out && c.fs_4k)
      ok = 1'b0;
    if (c.fs_4k && (c.bclk_out || c.bclk_rate != RATE_2M048))
      ok = 1'b0;
    for (int i = 0; i < 2; i++)
      if (c.lc_clk_out[i] && c.lc_rate[i] >= c.bclk_rate)
        ok = 1'b0;
    return ok;
  endfunction

  // ***************************************************
  // AXI4-Lite slave
  // ***************************************************
  assign aw_hs = s_axi_awvalid_i & s_axi_awready_o;
  assign w_hs = s_axi_wvalid_i & s_axi_wready_o;
  assign ar_hs = s_axi_arvalid_i & s_axi_arready_o;
  assign do_wr = aw_pend_q & w_pend_q;
  assign aw_pend_d = aw_pend_q ? ~do_wr : aw_hs;
  assign w_pend_d = w_pend_q ? ~do_wr : w_hs;
  assign bvalid_d = do_wr | (s_axi_bvalid_o & ~s_axi_bready_i);
  assign rvalid_d = ar_hs | (s_axi_rvalid_o & ~s_axi_rready_i);
  assign busy = req_q ^ ack_s2_q;
  assign wr_ctrl = aw_addr_q[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2];
  assign wr_status = aw_addr_q[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2];
  assign rd_ctrl = s_axi_araddr_i[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2];
  assign rd_status = s_axi_araddr_i[ADDR_W-1:2] == STATUS_OFFSET[ADDR_W-1:2];
  assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign cfg_new = ppm_cfg_t'((cfg_q & ~wmask[CTRL_WIDTH-1:0]) | (w_data_q[CTRL_WIDTH-1:0] & wmask[CTRL_WIDTH-1:0]));
  // A change while the link has not yet taken the previous one would tear the crossing
  assign ctrl_bad = busy | ~cfg_ok(cfg_new);
  assign ctrl_take = do_wr & wr_ctrl & ~ctrl_bad;
  assign err_clr = do_wr & wr_status & w_strb_q[0] & w_data_q[ST_CFG_ERR];
  assign bresp_d = !(wr_ctrl || wr_status) ? RESP_DECERR : (wr_ctrl && ctrl_bad) ? RESP_SLVERR : RESP_OKAY;
  assign rdata_d = rd_ctrl ? 32'(cfg_q) : rd_status ? 32'({lin_s2_q, busy, err_q}) : 32'h00000000;
  assign rresp_d = (rd_ctrl || rd_status) ? RESP_OKAY : RESP_DECERR;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      aw_pend_q <= 1'b0;
      w_pend_q <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= RESP_OKAY;
      s_axi_rdata_o <= 32'h00000000;
    end
    else
    begin
      aw_pend_q <= aw_pend_d;
      w_pend_q <= w_pend_d;
      s_axi_awready_o <= ~aw_pend_d & ~bvalid_d;
      s_axi_wready_o <= ~w_pend_d & ~bvalid_d;
      s_axi_bvalid_o <= bvalid_d;
      s_axi_arready_o <= ~rvalid_d;
      s_axi_rvalid_o <= rvalid_d;
      if (do_wr)
        s_axi_bresp_o <= bresp_d;
      if (ar_hs)
      begin
        s_axi_rdata_o <= rdata_d;
        s_axi_rresp_o <= rresp_d;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (aw_hs)
      aw_addr_q <= s_axi_awaddr_i;
    if (w_hs)
    begin
      w_data_q <= s_axi_wdata_i;
      w_strb_q <= s_axi_wstrb_i;
    end
  end

  // ***************************************************
  // Configuration and status
  // ***************************************************
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      cfg_q <= ppm_cfg_t'(CTRL_RESET);
      req_q <= 1'b0;
      err_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      lin_s1_q <= 2'h0;
      lin_s2_q <= 2'h0;
    end
    else
    begin
      if (ctrl_take)
      begin
        cfg_q <= cfg_new;
        req_q <= ~req_q;
      end
      // A refused setting raised in the same cycle as a clear stays set
      if (do_wr && wr_ctrl && ctrl_bad)
        err_q <= 1'b1;
      else if (err_clr)
        err_q <= 1'b0;
      ack_s1_q <= lack_q;
      ack_s2_q <= ack_s1_q;
      lin_s1_q <= line_collision_o | line_cts_o;
      lin_s2_q <= lin_s1_q;
    end
  end

  assign pcm_bit_clock_oe_o = cfg_q.bclk_out;

  // ***************************************************
  // Link domain: reset, configuration take-over, pin sampling
  // ***************************************************
  logic lrst_s1_q;
  logic lrst_q;
  logic req_s1_q;
  logic req_s2_q;
  ppm_cfg_t lcfg_q;
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic fs_s3_q;
  logic [FRAME_CNT_W-1:0] fcnt_q;
  logic [FRAME_CNT_W-1:0] frame_last;
  logic [N_PORTS-1:0] own;
  logic [1:0] lc_tx_oe;
  logic [1:0] lc_drv_n;
  logic [1:0] lc_clk;
  logic [1:0] lc_rx;
  logic [1:0] lc_col;
  logic [1:0] lc_cts;
  logic [1:0] lc_ext;
  logic [N_PORTS-1:0] tx_d;
  logic [N_PORTS-1:0] oe_d;
  logic [N_PORTS-1:0] drv_n_d;
  logic [1:0] weak_d;

  always_ff @(posedge pcm_bit_clk_i)
  begin
    lrst_s1_q <= srst_i;
    lrst_q <= lrst_s1_q;
    pin_s1_q <= {pcm_tx_port_i[3:2], pcm_frame_sync_i, pcm_rx_port_i};
    pin_s2_q <= pin_s1_q;
  end

  always_ff @(posedge pcm_bit_clk_i)
  begin
    if (lrst_q)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      lack_q <= 1'b0;
      lcfg_q <= ppm_cfg_t'(CTRL_RESET);
      fs_s3_q <= 1'b0;
      fcnt_q <= '0;
    end
    else
    begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      // The staged word is frozen while busy, so taking it whole is safe
      if (req_s2_q != lack_q)
      begin
        lcfg_q <= cfg_q;
        lack_q <= req_s2_q;
      end
      fs_s3_q <= pin_s2_q[4];
      fcnt_q <= (fcnt_q >= frame_last) ? '0 : fcnt_q + 1'b1;
    end
  end

  // Frame length in data clock cycles gives an 8 kHz frame at every rate
  assign frame_last = FRAME_CNT_W'((FRAME_BITS_BASE << lcfg_q.bclk_rate) - 1);

  // ***************************************************
  // Line-controller channels 2 and 3
  // ***************************************************
  for (genvar g = 0; g < 2; g++)
  begin : g_lc
    ppm_lc_if lc();
    assign lc.sel = lcfg_q.lc_sel[g];
    assign lc.async_mode = lcfg_q.lc_async[g];
    assign lc.clk_out = lcfg_q.lc_clk_out[g];
    assign lc.div = 2'(lcfg_q.bclk_rate - lcfg_q.lc_rate[g] - 2'h1);
    assign lc.tx_bit = line_tx_i[g];
    assign lc.tx_valid = line_tx_valid_i[g];
    assign lc.rts = line_rts_i[g];
    assign lc.rx_s = pin_s2_q[g];
    assign lc.cxd_s = pin_s2_q[g+2];
    assign lc.clk_s = pin_s2_q[g+5];
    ppm_lc_chan u_chan (
      .clk_i(pcm_bit_clk_i),
      .rst_i(lrst_q),
      .lc(lc.chan)
    );
    assign lc_tx_oe[g] = lc.tx_oe_d;
    assign lc_drv_n[g] = lc.drv_n_d;
    assign lc_clk[g] = lc.clk_d;
    assign lc_rx[g] = lc.rx_d;
    assign lc_col[g] = lc.col_d;
    assign lc_cts[g] = lc.cts_d;
    assign lc_ext[g] = lc.ext_clk_d;
  end

  assign own = {lcfg_q.lc_sel, lcfg_q.lc_sel};

  // ***************************************************
  // Shared pin selection
  // ***************************************************
  always_comb
  begin
    for (int p = 0; p < N_PORTS; p++)
    begin
      if (own[p] && p < 2)
      begin
        tx_d[p] = 1'b0;
        oe_d[p] = lc_tx_oe[p%2];
        drv_n_d[p] = lc_drv_n[p%2];
      end
      else if (own[p])
      begin
        tx_d[p] = lc_clk[p%2];
        oe_d[p] = lcfg_q.lc_clk_out[p%2];
        drv_n_d[p] = 1'b1;
      end
      else
      begin
        tx_d[p] = pcm_tx_data_i[p];
        oe_d[p] = lcfg_q.tx_en[p] & pcm_tx_valid_i[p];
        drv_n_d[p] = ~oe_d[p];
      end
    end
    for (int k = 0; k < 2; k++)
      weak_d[k] = own[k+2] ? ~lcfg_q.lc_clk_out[k] : ~lcfg_q.tx_en[k+2];
  end

  always_ff @(posedge pcm_bit_clk_i)
  begin
    if (lrst_q)
    begin
      pcm_tx_port_o <= '0;
      pcm_tx_port_oe_o <= '0;
      pcm_drv_enable_n_o <= '1;
      pcm_tx_weak_low_o <= 2'h3;
      pcm_frame_sync_o <= 1'b0;
      pcm_frame_sync_oe_o <= 1'b0;
      pcm_frame_pulse_o <= 1'b0;
      pcm_rx_data_o <= '0;
      line_rx_o <= 2'h0;
      line_collision_o <= 2'h0;
      line_cts_o <= 2'h0;
      line_ext_clk_o <= 2'h0;
    end
    else
    begin
      pcm_tx_port_o <= tx_d;
      pcm_tx_port_oe_o <= oe_d;
      pcm_drv_enable_n_o <= drv_n_d;
      pcm_tx_weak_low_o <= weak_d;
      pcm_frame_sync_o <= lcfg_q.fs_out & (fcnt_q == '0);
      pcm_frame_sync_oe_o <= lcfg_q.fs_out;
      pcm_frame_pulse_o <= lcfg_q.fs_out ? (fcnt_q == '0) : (pin_s2_q[4] & ~fs_s3_q);
      pcm_rx_data_o <= pin_s2_q[3:0] & ~own;
      line_rx_o <= lc_rx;
      line_collision_o <= lc_col;
      line_cts_o <= lc_cts;
      line_ext_clk_o <= lc_ext;
    end
  end

endmodule

/* ppm_top_sva.sv */
/*
  Concurrent checks on the ppm_top ports: bus handshakes and shared pin timing.
  Assumes it is bound into ppm_top and that the link clock is the PCM data clock.
*/
`timescale 1ns/1ps
module ppm_top_sva #(
  parameter int N_PORTS = 4
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic pcm_bit_clk_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic pcm_frame_sync_o,
  input wire logic [N_PORTS-1:0] pcm_rx_port_i,
  input wire logic [N_PORTS-1:0] pcm_tx_port_o,
  input wire logic [N_PORTS-1:0] pcm_tx_port_oe_o,
  input wire logic [N_PORTS-1:0] pcm_drv_enable_n_o,
  input wire logic [N_PORTS-1:0] pcm_tx_valid_i,
  input wire logic [N_PORTS-1:0] pcm_rx_data_o,
  input wire logic [1:0] line_tx_valid_i,
  input wire logic [1:0] line_rts_i
);
  // ****************************************
  // Bus side
  // ****************************************
  sequence wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  wr_answer_a: assert property (@(posedge clock_i) disable iff (srst_i) wr_taken |-> ##[1:3] s_axi_bvalid_o)
    else $error("write response missing");
  rd_answer_a: assert property (@(posedge clock_i) disable iff (srst_i) rd_taken |=> s_axi_rvalid_o)
    else $error("read response late");
  bresp_hold_a: assert property (@(posedge clock_i) disable iff (srst_i)
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  rdata_hold_a: assert property (@(posedge clock_i) disable iff (srst_i)
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  wr_block_a: assert property (@(posedge clock_i) disable iff (srst_i)
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answering");
  rd_block_a: assert property (@(posedge clock_i) disable iff (srst_i) s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answering");
  // ****************************************
  // Link side
  // ****************************************
  tx_drive_cause_a: assert property (@(posedge pcm_bit_clk_i) disable iff (srst_i)
    pcm_tx_port_oe_o[0] |-> $past(pcm_tx_valid_i[0] || line_tx_valid_i[0]))
    else $error("port 0 driven without valid data");
  open_drain_a: assert property (@(posedge pcm_bit_clk_i) disable iff (srst_i)
    pcm_tx_port_oe_o[1] && !$past(pcm_tx_valid_i[1]) |-> !pcm_tx_port_o[1])
    else $error("line transmit drives high");
  port_drv_en_a: assert property (@(posedge pcm_bit_clk_i) disable iff (srst_i)
    !pcm_drv_enable_n_o[2] |-> $past(pcm_tx_valid_i[2]))
    else $error("port 2 driver enabled without valid");
  line_drv_en_a: assert property (@(posedge pcm_bit_clk_i) disable iff (srst_i)
    !pcm_drv_enable_n_o[0] |-> $past(pcm_tx_valid_i[0] || line_tx_valid_i[0] || line_rts_i[0]))
    else $error("shared driver enabled without cause");
  fs_single_a: assert property (@(posedge pcm_bit_clk_i) disable iff (srst_i)
    pcm_frame_sync_o |=> !pcm_frame_sync_o [*8])
    else $error("frame sync pulse too long");
  rx_latency_a: assert property (@(posedge pcm_bit_clk_i) disable iff (srst_i)
    pcm_rx_data_o[3] |-> $past(pcm_rx_port_i[3], 3))
    else $error("receive bit without pin level");
endmodule
bind ppm_top ppm_top_sva #(.N_PORTS(N_PORTS)) u_sva (.*);

/* ppm_top_tb.sv */
/*
  Self-checking bench for ppm_top: AXI4-Lite tasks plus link-side stimulus.
  Assumes a 40 ns system clock and a free-running 125 ns data clock.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module ppm_top_tb;
  import ppm_pkg::*;
  logic clock_i = 1'b0, lclk = 1'b0, srst_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, v;
  logic [1:0] r, bresp, rresp, ltx = 2'h0, ltxv = 2'h0, lrts = 2'h0, lrx, lcol, lcts, wl, lext;
  logic [3:0] ptx_d = 4'h0, ptx_v = 4'h0, rxl = 4'h0, ptx_o, ptx_oe, drv_n, rxd, pin_tx;
  logic awready, wready, bvalid, arready, rvalid, fs_o, fs_oe, fs_pin, bclk_oe, fpulse;
  logic [31:0] rdata;
  int err_count = 0, checks_done = 0, n;
  always #20 clock_i = ~clock_i;
  always #62.5 lclk = ~lclk;
  ppm_top dut (.clock_i(clock_i), .srst_i(srst_i), .pcm_bit_clk_i(lclk),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .pcm_frame_sync_i(fs_pin), .pcm_frame_sync_o(fs_o), .pcm_frame_sync_oe_o(fs_oe),
    .pcm_bit_clock_oe_o(bclk_oe), .pcm_rx_port_i(rxl), .pcm_tx_port_i(pin_tx), .pcm_tx_port_o(ptx_o),
    .pcm_tx_port_oe_o(ptx_oe), .pcm_tx_weak_low_o(wl), .pcm_drv_enable_n_o(drv_n),
    .pcm_tx_data_i(ptx_d), .pcm_tx_valid_i(ptx_v), .pcm_rx_data_o(rxd), .pcm_frame_pulse_o(fpulse),
    .line_tx_i(ltx), .line_tx_valid_i(ltxv), .line_rts_i(lrts), .line_rx_o(lrx),
    .line_collision_o(lcol), .line_cts_o(lcts), .line_ext_clk_o(lext));
  ppm_highway_model u_far (.clk_i(lclk), .fs_drive_i(fs_oe), .fs_value_i(fs_o), .tx_value_i(ptx_o),
    .tx_oe_i(ptx_oe), .weak_low_i(wl), .fs_pin_o(fs_pin), .tx_pin_o(pin_tx));
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clock_i); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clock_i); while (!bvalid);
    // Late ready makes the slave hold its answer for a cycle
    bready <= 1'b1;
    @(posedge clock_i);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock_i); while (!rvalid);
    rready <= 1'b1;
    @(posedge clock_i);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // Next CTRL write is refused while the link still takes the last one
  task automatic cfg(input logic [31:0] d, input logic [1:0] e);
    wr(CTRL_OFFSET, d, r);
    `CHK(r, e)
    do rd(STATUS_OFFSET, v, r); while (v[ST_BUSY] !== 1'b0);
  endtask
  task automatic lwait(input int k);
    repeat (k) @(posedge lclk);
  endtask
  initial
  begin
    repeat (10) @(posedge clock_i);
    repeat (2) @(posedge lclk);
    @(posedge clock_i);
    srst_i <= 1'b0;
    lwait(3);
    `CHK(drv_n, 4'hF)
    `CHK(ptx_oe, 4'h0)
    `CHK(wl, 2'h3)
    `CHK(pin_tx[3:2], 2'h0)
    rd(CTRL_OFFSET, v, r);
    `CHK(v, 32'h0)
    $display("Test reset done");
    rd(8'h10, v, r);
    `CHK(r, RESP_DECERR)
    wr(8'h10, 32'hFFFFFFFF, r);
    `CHK(r, RESP_DECERR)
    cfg(32'h3, RESP_SLVERR);
    rd(STATUS_OFFSET, v, r);
    `CHK(v[ST_CFG_ERR], 1'b1)
    cfg(32'h6, RESP_SLVERR);
    cfg(32'hA, RESP_SLVERR);
    cfg(32'h2000, RESP_SLVERR);
    rd(CTRL_OFFSET, v, r);
    `CHK(v, 32'h0)
    wr(STATUS_OFFSET, 32'h1, r);
    rd(STATUS_OFFSET, v, r);
    `CHK(v[ST_CFG_ERR], 1'b0)
    cfg(32'h2, RESP_OKAY);
    for (int k = 0; k < 4; k++)
    begin
      cfg(32'h4 | (32'(k) << 3), RESP_OKAY);
      rd(CTRL_OFFSET, v, r);
      `CHK(v, 32'h4 | (32'(k) << 3))
      `CHK(bclk_oe, 1'b1)
    end
    $display("Test config done");
    cfg(32'h1E1, RESP_OKAY);
    n = 0;
    do @(posedge lclk); while (fs_o !== 1'b1);
    `CHK(fpulse, 1'b1)
    do begin @(posedge lclk); n++; end while (fs_o !== 1'b1);
    `CHK(n, 256)
    `CHK(fs_oe, 1'b1)
    @(posedge lclk);
    ptx_d <= 4'h3;
    ptx_v <= 4'h5;
    rxl <= 4'h9;
    lwait(5);
    `CHK(drv_n, 4'hA)
    `CHK(ptx_oe, 4'h5)
    `CHK(ptx_o & 4'h5, 4'h1)
    `CHK(rxd, 4'h9)
    ptx_v <= 4'h0;
    lwait(2);
    `CHK(drv_n, 4'hF)
    $display("Test ports done");
    cfg(32'h7E0, RESP_OKAY);
    @(posedge lclk);
    ptx_v <= 4'h5;
    ltx <= 2'h1;
    ltxv <= 2'h3;
    rxl <= 4'h6;
    lwait(5);
    `CHK(ptx_oe[1:0], 2'h2)
    `CHK(ptx_o[1], 1'b0)
    `CHK(lext, 2'h0)
    `CHK(drv_n, 4'hC)
    `CHK(lrx, 2'h2)
    `CHK(lcol, 2'h1)
    `CHK(rxd, 4'h0)
    ltxv <= 2'h0;
    lwait(2);
    `CHK(drv_n[1:0], 2'h3)
    cfg(32'h1FE0, RESP_OKAY);
    @(posedge lclk);
    lrts <= 2'h1;
    lwait(5);
    `CHK(drv_n[1:0], 2'h2)
    `CHK(lcts, 2'h1)
    cfg(32'h2208, RESP_OKAY);
    lwait(4);
    `CHK(ptx_oe[2], 1'b1)
    n = 0;
    repeat (8)
    begin
      v[0] = ptx_o[2];
      @(posedge lclk);
      if (ptx_o[2] !== v[0]) n++;
    end
    `CHK(n, 8)
    $display("Test line done");
    give_verdict();
  end
  initial
  begin
    #2000000;
    err_count++;
    give_verdict();
  end
endmodule
